// >>> rtl/sot_defs.svh
// Offsets, field positions, reset values and counts of the termination controller
`ifndef SOT_DEFS_SVH
`define SOT_DEFS_SVH
`define SOT_CFG_OFFSET 8'h00
`define SOT_STAT_OFFSET 8'h04
`define SOT_CFG_RESET 16'h0465
`define SOT_CWL_LSB 0
`define SOT_CL_LSB 4
`define SOT_AL_LSB 8
`define SOT_NOM_LSB 10
`define SOT_WRT_LSB 13
`define SOT_DLLPD_BIT 15
`define SOT_LAT_MINUS 6'h02
`define SOT_HOLD_CHOP 3'h4
`define SOT_HOLD_FULL 3'h6
`define SOT_AGE_MAX 4'hF
`endif

// >>> rtl/sot_pkg.sv
// Types and latency arithmetic of the termination controller
`include "sot_defs.svh"
package sot_pkg;
    typedef enum logic [1:0] {
        SOT_AL_ZERO = 2'h0,
        SOT_AL_CL_M1 = 2'h1,
        SOT_AL_CL_M2 = 2'h2,
        SOT_AL_RSVD = 2'h3
    } sot_al_t;

    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic [15:0] cfg;
        logic sync;
        logic [4:0] lat;
        logic [2:0] wr_cnt;
        logic wr_sel;
        logic [3:0] cfg_age;
    } sot_state_t;

    // Latency = write latency - 2, never below one cycle
    function automatic logic [4:0] sot_lat_calc(input logic [3:0] write_cas_latency, input logic [3:0] cl,
                                                 input logic [1:0] alf);
        logic [5:0] al;
        logic [5:0] wl;
        al = 6'h00;
        if (alf == SOT_AL_CL_M1) begin
            al = {2'h0, cl} - 6'h01;
        end else if (alf == SOT_AL_CL_M2) begin
            al = {2'h0, cl} - 6'h02;
        end
        wl = {2'h0, write_cas_latency} + al;
        if (wl < 6'h03) begin
            return 5'h01;
        end
        return 5'(wl - `SOT_LAT_MINUS);
    endfunction
endpackage

// >>> rtl/sot_delay_line.sv
// Variable-tap delay line with registered output
`timescale 1ns/10ps
module sot_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32,
    parameter int TAP_W = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    input wire logic [TAP_W-1:0] tap,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] sh;
        logic [WIDTH-1:0] q;
    } sot_dly_state_t;

    sot_dly_state_t s_q;
    sot_dly_state_t s_d;

    // q at edge t+tap equals d sampled at edge t
    always_comb begin
        s_d = s_q;
        s_d.sh = {s_q.sh[DEPTH-2:0], d};
        if (tap == '0) begin
            s_d.q = d;
        end else begin
            s_d.q = s_q.sh[tap - TAP_W'(1)];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;
endmodule

// >>> rtl/sot_ctrl.sv
// Synchronous on-die termination controller with AHB-Lite configuration
`timescale 1ns/10ps
`include "sot_defs.svh"
// Overview of operation
// - Sync mode needs DLL locked and termination enabled
// - Precharge power-down keeps sync per DLL power-down bit
// - Pin high/low switches termination after latency
// - Both latencies equal write latency minus two
// - Pin delayed by programmed additive latency
// - Write switches to write termination, then back
// - Dynamic termination enabled by either write bit
module sot_ctrl #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Memory-side inputs
    input wire logic termination_ctl_pin,
    input wire logic wr_cmd,
    input wire logic burst_chop_four,
    input wire logic cke,
    input wire logic bank_active,
    input wire logic dll_locked,
    // Termination outputs
    output logic sync_mode,
    output logic term_en,
    output logic write_termination,
    output logic nominal_termination
);
    sot_pkg::sot_state_t s_q;
    sot_pkg::sot_state_t s_d;
    logic nom_on;
    logic dyn_on;
    logic pin_smp;
    logic wr_dly;
    logic [1:0] wr_in;
    logic [1:0] wr_out;
    logic [4:0] wr_tap;
    logic [15:0] cfg_next;

    assign nom_on = s_q.cfg[`SOT_NOM_LSB +: 3] != 3'h0;
    assign dyn_on = s_q.cfg[`SOT_WRT_LSB +: 2] != 2'h0;
    // Pin sampled only in sync mode; asynchronous path is outside this block
    assign pin_smp = termination_ctl_pin & s_q.sync;
    assign wr_in = {burst_chop_four, wr_cmd & s_q.sync & dyn_on};
    // Write path taps one earlier so the counter flop lands on the latency edge
    assign wr_tap = s_q.lat - 5'h01;
    assign wr_dly = wr_out[0];

    sot_delay_line #(.WIDTH(1), .DEPTH(DEPTH), .TAP_W(5)) u_pin_dly (
        .clk(hclk),
        .rst_n(hresetn),
        .d(pin_smp),
        .tap(s_q.lat),
        .q(term_en)
    );

    sot_delay_line #(.WIDTH(2), .DEPTH(DEPTH), .TAP_W(5)) u_wr_dly (
        .clk(hclk),
        .rst_n(hresetn),
        .d(wr_in),
        .tap(wr_tap),
        .q(wr_out)
    );

    always_comb begin
        s_d = s_q;
        cfg_next = s_q.cfg;
        // Data phase of a write lands here; hready is always high
        if (s_q.ap_valid && s_q.ap_write && s_q.ap_addr == `SOT_CFG_OFFSET) begin
            cfg_next = hwdata[15:0];
        end
        s_d.cfg = cfg_next;
        s_d.ap_valid = hsel && htrans[1] && hready;
        s_d.ap_write = hwrite;
        s_d.ap_addr = {haddr[7:2], 2'h0};
        if (s_d.ap_valid && !hwrite) begin
            // Read sees a write still in its data phase
            unique case ({haddr[7:2], 2'h0})
                `SOT_CFG_OFFSET: s_d.hrdata = {16'h0000, cfg_next};
                `SOT_STAT_OFFSET: s_d.hrdata = {24'h000000, s_q.wr_sel, term_en,
                                                s_q.sync, s_q.lat};
                default: s_d.hrdata = 32'h00000000;
            endcase
        end
        if (cfg_next != s_q.cfg) begin
            s_d.cfg_age = 4'h0;
        end else if (s_q.cfg_age != `SOT_AGE_MAX) begin
            s_d.cfg_age = s_q.cfg_age + 4'h1;
        end
        s_d.lat = sot_pkg::sot_lat_calc(s_q.cfg[`SOT_CWL_LSB +: 4],
                                        s_q.cfg[`SOT_CL_LSB +: 4],
                                        s_q.cfg[`SOT_AL_LSB +: 2]);
        // Precharge power-down keeps sync only with the DLL kept on
        s_d.sync = dll_locked && (nom_on || dyn_on) &&
                   (cke || bank_active || s_q.cfg[`SOT_DLLPD_BIT]);
        // Window length 4 or 6 equals hold plus latency minus switch latency
        if (wr_dly) begin
            s_d.wr_cnt = wr_out[1] ? `SOT_HOLD_CHOP : `SOT_HOLD_FULL;
        end else if (s_q.wr_cnt != 3'h0) begin
            s_d.wr_cnt = s_q.wr_cnt - 3'h1;
        end
        s_d.wr_sel = (s_d.wr_cnt != 3'h0) && dyn_on;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00, hrdata: 32'h00000000,
                     cfg: `SOT_CFG_RESET, sync: 1'b0, lat: 5'h01, wr_cnt: 3'h0,
                     wr_sel: 1'b0, cfg_age: 4'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.hrdata;
    assign sync_mode = s_q.sync;
    assign write_termination = term_en & s_q.wr_sel;
    assign nominal_termination = term_en & ~s_q.wr_sel & nom_on;

    logic cfg_settled;
    assign cfg_settled = s_q.cfg_age == `SOT_AGE_MAX;

    sequence sq_win_chop;
        s_q.wr_sel [*4] ##1 !s_q.wr_sel;
    endsequence

    // Starts two cycles into the window so no later write can reload it unseen
    sequence sq_win_full;
        $past(s_q.wr_sel, 2) && $past(s_q.wr_sel) && s_q.wr_sel ##1 s_q.wr_sel [*3]
            ##1 !s_q.wr_sel;
    endsequence

    a_sync_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (dll_locked && !nom_on && !dyn_on) |=> !s_q.sync)
        else $error("sync mode without any termination enabled");

    a_sync_powerdown: assert property (@(posedge hclk) disable iff (!hresetn)
        (dll_locked && nom_on && !cke && !bank_active && $stable(s_q.cfg))
        |=> (s_q.sync == $past(s_q.cfg[`SOT_DLLPD_BIT])))
        else $error("power-down sync choice wrong");

    a_term_on_lat: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && s_q.sync && termination_ctl_pin)
        |-> ##4 term_en)
        else $error("termination not on after latency");

    a_term_off_lat: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && s_q.sync && !termination_ctl_pin)
        |-> ##4 !term_en)
        else $error("termination not off after latency");

    a_lat_formula: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.cfg[`SOT_AL_LSB +: 2] == 2'h0 && s_q.cfg[`SOT_CWL_LSB +: 4] > 4'h4)
        |-> s_q.lat == 5'(s_q.cfg[`SOT_CWL_LSB +: 4] - 4'h2))
        else $error("latency not write latency minus two");

    a_lat_additive: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.cfg[`SOT_AL_LSB +: 2] == 2'h1 && s_q.cfg[`SOT_CWL_LSB +: 4] > 4'h4
         && s_q.cfg[`SOT_CL_LSB +: 4] > 4'h1)
        |-> s_q.lat == 5'({1'b0, s_q.cfg[`SOT_CWL_LSB +: 4]} + {1'b0, s_q.cfg[`SOT_CL_LSB +: 4]}
                          - 5'h03))
        else $error("additive latency not applied");

    a_wr_switch_chop: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && wr_cmd && burst_chop_four && s_q.sync && dyn_on)
        |-> ##4 s_q.wr_sel [*4])
        else $error("chop write window wrong");

    a_wr_switch_full: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && wr_cmd && !burst_chop_four && s_q.sync && dyn_on
         && !s_q.wr_sel) ##1 (!wr_cmd [*6]) |-> sq_win_full)
        else $error("full write window wrong");

    a_wr_chop_end: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && wr_cmd && burst_chop_four && s_q.sync && dyn_on
         && !s_q.wr_sel) ##1 (!wr_cmd [*4]) |-> sq_win_chop)
        else $error("chop write window did not end");

    a_dyn_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !dyn_on |=> !s_q.wr_sel)
        else $error("write termination with dynamic mode off");

    a_term_clocked: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_settled && s_q.lat == 5'h03 && !s_q.sync [*5]) |-> !term_en)
        else $error("termination on outside sync mode");
endmodule

// >>> verification/sot_mc_model.sv
// Memory-controller model that drives the termination pin and write commands
`timescale 1ns/10ps
module sot_mc_model (
    // Clock
    input wire logic hclk,
    // Pins toward the block
    output logic termination_ctl_pin,
    output logic wr_cmd,
    output logic burst_chop_four
);
    initial begin
        termination_ctl_pin = 1'b0;
        wr_cmd = 1'b0;
        burst_chop_four = 1'b0;
    end
    // Pin low between bursts leaves room for reads
    task automatic burst(input int hold, input logic wr, input logic chop);
        @(posedge hclk);
        termination_ctl_pin <= 1'b1;
        wr_cmd <= wr;
        burst_chop_four <= chop;
        @(posedge hclk);
        wr_cmd <= 1'b0;
        burst_chop_four <= ~chop;
        // Caller gives the later of both hold windows
        repeat (hold - 1) @(posedge hclk);
        termination_ctl_pin <= 1'b0;
    endtask
endmodule

// >>> verification/sync_odt_termination_ctrl_test.sv
// Self-checking bench for the termination controller
`timescale 1ns/10ps
module sync_odt_termination_ctrl_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, pin, wr, bc4, sync_mode, term_en, wterm, nterm;
    logic [31:0] hrdata, rd;
    logic cke = 1'b1;
    logic bank_active = 1'b0;
    logic dll_locked = 1'b1;
    int failures = 0;
    int samples_checked = 0;
    logic [19:0] syn [6] = '{20'h04654, 20'h0465D, 20'h04658, 20'h0465B, 20'h84659, 20'h0065E};
    int lat [4] = '{3, 8, 7, 3};
    logic [31:0] dyn [5] = '{32'h24650606, 32'h24650414, 32'h44650414, 32'h04650600,
        32'h20650806};
    always #12.5 hclk = ~hclk;
    sot_ctrl sot_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .termination_ctl_pin(pin),
        .wr_cmd(wr), .burst_chop_four(bc4), .cke(cke), .bank_active(bank_active),
        .dll_locked(dll_locked), .sync_mode(sync_mode), .term_en(term_en),
        .write_termination(wterm), .nominal_termination(nterm));
    sot_mc_model sot_mc_model_inst (.hclk(hclk), .termination_ctl_pin(pin), .wr_cmd(wr),
        .burst_chop_four(bc4));
    task automatic conclude();
        $display("Counts: %0d checked, %0d mismatched", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Zero-wait slave, but never assume it
    task automatic wait_rdy();
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) begin
                return;
            end
        end
        failures++;
        conclude();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    // Counts are taken one step after each edge
    task automatic run(input int hold, input logic w, input logic c, input int e_on,
        input int e_wr, input int e_nom);
        int d_on = 0;
        int d_wr = 0;
        int n_on = 0;
        int n_wr = 0;
        int n_nom = 0;
        // Let the configuration settle so the latency assertions engage
        repeat (16) @(posedge hclk);
        fork
            sot_mc_model_inst.burst(hold, w, c);
            for (int i = 0; i < 25; i++) begin
                @(posedge hclk);
                #1;
                if (term_en === 1'b1 && d_on == 0) begin
                    d_on = i;
                end
                if (wterm === 1'b1 && d_wr == 0) begin
                    d_wr = i;
                end
                n_on += int'(term_en === 1'b1);
                n_wr += int'(wterm === 1'b1);
                n_nom += int'(nterm === 1'b1);
            end
        join
        chk("on latency", e_on, d_on);
        chk("on cycles", (e_on > 0) ? hold : 0, n_on);
        chk("write start", (e_wr > 0) ? e_on : 0, d_wr);
        chk("write cycles", e_wr, n_wr);
        chk("nominal cycles", e_nom, n_nom);
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk("cfg reset", 32'h00000465, rd);
        chk("okay response", 32'h00000000, {31'h0, hresp});
        bus(1'b1, 8'h04, 32'hFFFFFFFF);
        bus(1'b0, 8'h04, 32'h0);
        chk("stat", 32'h00000023, rd);
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h00000000, rd);
        $display("registers done");
        foreach (syn[i]) begin
            bus(1'b1, 8'h00, {16'h0000, syn[i][19:4]});
            dll_locked <= syn[i][3];
            cke <= syn[i][2];
            bank_active <= syn[i][1];
            repeat (3) @(posedge hclk);
            #1;
            chk("sync_mode", {31'h0, syn[i][0]}, {31'h0, sync_mode});
        end
        $display("sync select done");
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 8'h00, 32'h00000465 | (f << 8));
            bus(1'b0, 8'h04, 32'h0);
            chk("stat lat", 32'h00000020 | lat[f], rd);
            run(4, 1'b0, 1'b0, lat[f] + 1, 0, 4);
        end
        @(posedge hclk);
        dll_locked <= 1'b0;
        run(4, 1'b0, 1'b0, 0, 0, 0);
        @(posedge hclk);
        dll_locked <= 1'b1;
        $display("latency done");
        foreach (dyn[i]) begin
            bus(1'b1, 8'h00, {16'h0000, dyn[i][31:16]});
            repeat (2) @(posedge hclk);
            run(dyn[i][15:8], 1'b1, dyn[i][4], 4, dyn[i][3:0],
                (dyn[i][28:26] != 3'h0) ? dyn[i][15:8] - dyn[i][3:0] : 0);
        end
        $display("dynamic write done");
        conclude();
    end
endmodule
